// ===== core/system_control_unit.v
`timescale 1ns/1ps
`include "sysctl_defines.vh"
module system_control_unit #(
   parameter IMP_ID = 8'h5a, // arbitrary implementation code
   parameter REV_ID = 8'h01 // arbitrary revision code
) (
   input wire clk, // cpu clock
   input wire rst_n, // async reset, low
   input wire req_valid, // instruction issued
   input wire [2:0] req_op, // operation code
   input wire [1:0] req_cop, // coprocessor number
   input wire [4:0] req_reg, // control register number
   input wire [63:0] req_wdata, // general register or memory data
   input wire req_in_jr_slot, // issued in register-jump delay slot
   input wire jr_commit, // register jump retiring
   input wire exc_valid, // exception taken
   input wire exc_error, // error-class trap
   input wire [4:0] exc_code, // cause code
   input wire exc_addr_err, // address error
   input wire [63:0] exc_badaddr, // faulting address
   input wire [63:0] exc_pc, // pc of faulting insn
   input wire irq_wake, // interrupt pending
   output reg [63:0] rd_data, // move-from result
   output reg rd_valid, // result strobe
   output reg cop_unusable, // coprocessor not present
   output reg redirect, // exception return jump
   output reg [63:0] redirect_pc, // return target
   output reg squash_next, // drop following insn
   output reg standby, // low-power state
   output reg kernel_mode // privileged mode
);

   // one-hot states: running, or parked in standby until woken
   localparam S_RUN = 2'b01;
   localparam S_WAIT = 2'b10;

   // sequencer state and its next value
   reg [1:0] state_q;
   reg [1:0] state_d;

   // mapped control registers, all kept at doubleword width
   reg [63:0] config_q;
   reg [63:0] fault_q;
   reg [63:0] status_q;
   reg [63:0] cause_q;
   reg [63:0] epc_q;

   // next values of the mapped registers
   reg [63:0] config_d;
   reg [63:0] fault_d;
   reg [63:0] status_d;
   reg [63:0] cause_d;
   reg [63:0] epc_d;

   // restore seen in a jump delay slot, parked until the jump retires
   reg rfe_pend_q;
   reg rfe_pend_d;

   // combinational helpers
   reg [63:0] wval;
   reg [63:0] rmux;
   reg [63:0] rd_word;
   reg [63:0] status_pop;
   reg [63:0] status_exc;
   reg [63:0] status_ret;
   reg [63:0] cause_new;
   reg kernel_d;

   // request decode
   wire is_cp0;
   wire running;
   wire go;
   wire op_mtc;
   wire op_mfc;
   wire op_dmtc;
   wire op_dmfc;
   wire op_rfe;
   wire op_eret;
   wire op_wait;
   wire op_ldc;
   wire dbl;
   wire wr;
   wire rd;
   wire eret_now;
   wire rfe_hit;
   wire rfe_apply;
   wire wr_ok;
   wire unit_absent;

   // per-register write selects
   wire sel_config;
   wire sel_status;
   wire sel_cause;
   wire sel_epc;

   // unit zero is always present; units one to three are refused
   assign is_cp0 = req_cop == `COP_ZERO;
   assign unit_absent = req_valid && !is_cp0 && req_cop < `NUM_COPROC;

   // unit-zero requests are ignored while parked in standby; absent units are still refused and exceptions still land
   assign running = state_q == S_RUN;
   assign go = req_valid && is_cp0 && running;

   // one strobe per operation code
   assign op_mtc = go && req_op == `OP_MTC;
   assign op_mfc = go && req_op == `OP_MFC;
   assign op_dmtc = go && req_op == `OP_DMTC;
   assign op_dmfc = go && req_op == `OP_DMFC;
   assign op_rfe = go && req_op == `OP_RFE;
   assign op_eret = go && req_op == `OP_ERET;
   assign op_wait = go && req_op == `OP_WAIT;
   assign op_ldc = go && req_op == `OP_LDC;

   // word forms use the low half only; doubleword forms carry all 64 bits
   assign dbl = op_dmtc || op_dmfc;
   assign wr = op_mtc || op_dmtc || op_ldc;
   assign rd = op_mfc || op_dmfc;

   // priority: exception, then return, then restore, then plain writes
   assign eret_now = op_eret && !exc_valid;
   assign rfe_hit = (op_rfe && !req_in_jr_slot) || (rfe_pend_q && jr_commit);
   assign rfe_apply = rfe_hit && !exc_valid && !op_eret;
   assign wr_ok = wr && !exc_valid && !op_eret && !rfe_hit;

   // only the writable slots decode; 8, 15 and unmapped slots drop writes
   assign sel_config = wr_ok && req_reg == `REG_CONFIG;
   assign sel_status = wr_ok && req_reg == `REG_STATUS;
   assign sel_cause = wr_ok && req_reg == `REG_CAUSE;
   assign sel_epc = wr_ok && req_reg == `REG_EPC;

   // word writes clear the upper half rather than keep stale bits
   always @* begin
      wval = req_wdata;
      if (!dbl) begin
         wval[`DW_MSB:`WORD_W] = {`WORD_W{1'b0}};
      end
   end

   // read mux over the 32 slots, unused slots read zero
   always @* begin
      rmux = {`DW{1'b0}};
      case (req_reg)
         `REG_CONFIG: rmux = config_q;
         `REG_FAULT: rmux = fault_q;
         `REG_STATUS: rmux = status_q;
         `REG_CAUSE: rmux = cause_q;
         `REG_EPC: rmux = epc_q;
         `REG_PROCESSOR_IDENT: rmux = {{`PROCESSOR_IDENT_PAD{1'b0}}, IMP_ID, REV_ID};
         default: rmux = {`DW{1'b0}};
      endcase
   end

   // word reads sign-extend bit 31 the way a 32-bit load would
   always @* begin
      rd_word = rmux;
      if (!dbl) begin
         rd_word[`DW_MSB:`WORD_W] = {`WORD_W{rmux[`WORD_MSB]}};
      end
   end

   // restore: previous mode and enable move down into the current pair
   always @* begin
      status_pop = status_q;
      status_pop[`ST_CUR_HI:`ST_IE] = status_q[`ST_POP_HI:`ST_POP_LO];
   end

   // taking an exception raises one level flag, which forces kernel mode
   always @* begin
      status_exc = status_q;
      if (exc_error) begin
         status_exc[`ST_ERL] = 1'b1;
      end else begin
         status_exc[`ST_EXL] = 1'b1;
      end
   end

   // return drops the error level first, as it is the outer trap
   always @* begin
      status_ret = status_q;
      if (status_q[`ST_ERL]) begin
         status_ret[`ST_ERL] = 1'b0;
      end else begin
         status_ret[`ST_EXL] = 1'b0;
      end
   end

   // new cause word: only the code field is filled, the rest reads zero
   always @* begin
      cause_new = {`DW{1'b0}};
      cause_new[`CAUSE_HI:`CAUSE_CODE] = exc_code;
   end

   // standby: parked until an interrupt or an exception wakes the core
   always @* begin
      state_d = state_q;
      case (state_q)
         S_RUN: begin
            if (op_wait) begin
               state_d = S_WAIT;
            end
         end
         S_WAIT: begin
            if (irq_wake || exc_valid) begin
               state_d = S_RUN;
            end
         end
         default: state_d = S_RUN;
      endcase
   end

   // a restore in the delay slot waits for its jump so both take effect together
   always @* begin
      rfe_pend_d = rfe_pend_q;
      if (op_rfe && req_in_jr_slot) begin
         rfe_pend_d = 1'b1;
      end else if (jr_commit) begin
         rfe_pend_d = 1'b0;
      end
   end

   // configuration: software-owned, written only by the move paths and the load path
   always @* begin
      config_d = config_q;
      if (sel_config) begin
         config_d = wval;
      end
   end

   // faulting address: hardware-owned, every address error overwrites it
   always @* begin
      fault_d = fault_q;
      if (exc_valid && exc_addr_err) begin
         fault_d = exc_badaddr;
      end
   end

   // status: exception beats return beats restore beats a software write
   always @* begin
      status_d = status_q;
      if (exc_valid) begin
         status_d = status_exc;
      end else if (op_eret) begin
         status_d = status_ret;
      end else if (rfe_apply) begin
         status_d = status_pop;
      end else if (sel_status) begin
         status_d = wval;
      end
   end

   // cause: every exception taken replaces the whole word
   always @* begin
      cause_d = cause_q;
      if (exc_valid) begin
         cause_d = cause_new;
      end else if (sel_cause) begin
         cause_d = wval;
      end
   end

   // return address: the faulting pc, or a software write between traps
   always @* begin
      epc_d = epc_q;
      if (exc_valid) begin
         epc_d = exc_pc;
      end else if (sel_epc) begin
         epc_d = wval;
      end
   end

   // kernel while either level flag is up or the mode field says kernel
   always @* begin
      kernel_d = status_q[`ST_EXL] || status_q[`ST_ERL] ||
         status_q[`ST_MODE_HI:`ST_KSU] == `MODE_KERNEL;
   end

   // sequencer register; reset leaves the core running, not parked
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_RUN;
         standby <= 1'b0;
      end else begin
         state_q <= state_d;
         standby <= state_d == S_WAIT;
      end
   end

   // register file; reset is taken like an error trap, the rest clears to zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         config_q <= {`DW{1'b0}};
         fault_q <= {`DW{1'b0}};
         status_q <= `STATUS_RST;
         cause_q <= `CAUSE_RST;
         epc_q <= {`DW{1'b0}};
         rfe_pend_q <= 1'b0;
      end else begin
         config_q <= config_d;
         fault_q <= fault_d;
         status_q <= status_d;
         cause_q <= cause_d;
         epc_q <= epc_d;
         rfe_pend_q <= rfe_pend_d;
      end
   end

   // move-from result; rd_data holds until the next read replaces it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= {`DW{1'b0}};
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd;
         if (rd) begin
            rd_data <= rd_word;
         end
      end
   end

   // refusal strobe for the absent units
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cop_unusable <= 1'b0;
      end else begin
         cop_unusable <= unit_absent;
      end
   end

   // exception return: jump to the saved pc and drop the following slot
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         redirect <= 1'b0;
         squash_next <= 1'b0;
         redirect_pc <= {`DW{1'b0}};
      end else begin
         redirect <= eret_now;
         squash_next <= eret_now;
         if (eret_now) begin
            redirect_pc <= epc_q;
         end
      end
   end

   // privilege follows status one cycle later, so it lags a status write by two
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         kernel_mode <= 1'b1;
      end else begin
         kernel_mode <= kernel_d;
      end
   end
endmodule

// ===== include/sysctl_defines.vh
`ifndef SYSCTL_DEFINES_VH
`define SYSCTL_DEFINES_VH
`define REG_CONFIG 5'h03
`define REG_FAULT 5'h08
`define REG_STATUS 5'h0c
`define REG_CAUSE 5'h0d
`define REG_EPC 5'h0e
`define REG_PROCESSOR_IDENT 5'h0f
`define OP_MTC 3'h0
`define OP_MFC 3'h1
`define OP_DMTC 3'h2
`define OP_DMFC 3'h3
`define OP_RFE 3'h4
`define OP_ERET 3'h5
`define OP_WAIT 3'h6
`define OP_LDC 3'h7
`define ST_IE 0
`define ST_EXL 1
`define ST_ERL 2
`define ST_KSU 4
`define ST_KUC 1
`define CAUSE_CODE 2
`define EXC_RESET 5'h1f
`define COP_ZERO 2'h0
`define DW 64
`define DW_MSB 63
`define WORD_W 32
`define WORD_MSB 31
`define PROCESSOR_IDENT_PAD 48
`define ST_CUR_HI 3
`define ST_POP_HI 5
`define ST_POP_LO 2
`define ST_MODE_HI 5
`define MODE_KERNEL 2'h0
`define CAUSE_HI 6
`define STATUS_RST 64'h0000_0000_0000_0004
`define CAUSE_RST 64'h0000_0000_0000_007c
`define NUM_COPROC 4
`endif

// ===== testbench/cpu_pipe_model.sv
`timescale 1ns/1ps
// issuing pipeline: one instruction per call, held across exactly one rising edge
module cpu_pipe_model (output reg req_valid, output reg [2:0] req_op, output reg [1:0] req_cop,
   output reg [4:0] req_reg, output reg [63:0] req_wdata, output reg req_in_jr_slot, output reg jr_commit,
   input wire clk);
   initial {req_valid, req_op, req_cop, req_reg, req_wdata, req_in_jr_slot, jr_commit} = 0;
   task issue(input [2:0] op, input [1:0] cp, input [4:0] rg, input [63:0] d);
      begin
         {req_valid, req_op, req_cop, req_reg, req_wdata} = {1'b1, op, cp, rg, d};
         @(negedge clk);
         req_valid = 0;
         req_wdata = ~d; // released data never repeats, so stale values cannot pass
      end
   endtask
   // an instruction sitting in a register-jump delay slot
   task issue_in_slot(input [2:0] op);
      begin
         {req_valid, req_op, req_cop, req_in_jr_slot} = {1'b1, op, 2'h0, 1'b1};
         @(negedge clk);
         {req_valid, req_in_jr_slot} = 2'b00;
      end
   endtask
   // the register jump retires for one cycle; t_restore calls it two cycles after its slot
   task commit_jump;
      begin
         jr_commit = 1;
         @(negedge clk);
         jr_commit = 0;
      end
   endtask
endmodule

// ===== testbench/sysctl_sva.sv
`timescale 1ns/1ps
module sysctl_chk #(parameter [7:0] IMP_ID = 8'h5a, parameter [7:0] REV_ID = 8'h01) (
   input wire clk, input wire rst_n, input wire req_valid, input wire [2:0] req_op, input wire [1:0] req_cop,
   input wire [4:0] req_reg, input wire exc_valid, input wire irq_wake, input wire [63:0] rd_data,
   input wire rd_valid, input wire cop_unusable, input wire redirect, input wire squash_next,
   input wire standby, input wire kernel_mode);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // a request that is neither refused in standby nor overtaken by an exception
   sequence s_go; req_valid && !standby && !exc_valid; endsequence
   property p_rd; s_go ##0 req_cop == 2'h0 && req_op == 3'h1 |=> rd_valid; endproperty
   a_rd: assert property (p_rd) else $error("no read result");
   property p_id;
      s_go ##0 req_cop == 2'h0 && req_op == 3'h1 && req_reg == 5'h0f |=> rd_data[15:0] == {IMP_ID, REV_ID};
   endproperty
   a_id: assert property (p_id) else $error("bad ident");
   property p_cop; s_go ##0 req_cop != 2'h0 |=> cop_unusable && !rd_valid; endproperty
   a_cop: assert property (p_cop) else $error("missing unit not flagged");
   property p_ret; s_go ##0 req_cop == 2'h0 && req_op == 3'h5 |=> redirect && squash_next; endproperty
   a_ret: assert property (p_ret) else $error("return lost");
   property p_wt; s_go ##0 req_cop == 2'h0 && req_op == 3'h6 ##1 !irq_wake |-> standby; endproperty
   a_wt: assert property (p_wt) else $error("no standby");
   property p_st; standby && !irq_wake && !exc_valid |=> standby; endproperty
   a_st: assert property (p_st) else $error("standby left early");
   property p_exc; exc_valid |-> ##[1:3] kernel_mode; endproperty
   a_exc: assert property (p_exc) else $error("exception not privileged");
   property p_rst; $rose(rst_n) |-> kernel_mode && !standby; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind system_control_unit sysctl_chk #(.IMP_ID(IMP_ID), .REV_ID(REV_ID)) i_chk (.*);

// ===== testbench/system_control_coproc_access_bench.sv
`timescale 1ns/1ps
`include "sysctl_defines.vh"
module system_control_coproc_access_bench;
   reg clk, rst_n, exc_valid, exc_error, exc_addr_err, irq_wake;
   reg [4:0] exc_code;
   reg [63:0] exc_badaddr, exc_pc;
   wire req_valid, req_in_jr_slot, jr_commit, rd_valid, cop_unusable, redirect, squash_next, standby, kernel_mode;
   wire [2:0] req_op;
   wire [1:0] req_cop;
   wire [4:0] req_reg;
   wire [63:0] req_wdata, rd_data, redirect_pc;
   integer error_cnt = 0, checked = 0;
   cpu_pipe_model i_pipe (.*);
   system_control_unit i_dut (.*);
   initial begin clk = 0; forever #2 clk = ~clk; end
   task chk(input [63:0] nm, input [63:0] e, input [63:0] g);
      begin
         checked = checked + 1;
         if (e !== g) begin error_cnt = error_cnt + 1; $display("[ERR] %0s exp %h got %h", nm, e, g); end
      end
   endtask
   task finish_test;
      begin
         $display("checked %0d errors %0d", checked, error_cnt);
         if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task rd(input [2:0] op, input [4:0] rg, input [63:0] e);
      begin i_pipe.issue(op, 2'h0, rg, 64'h0); chk("rd_data", e, rd_data); end
   endtask
   // reset values and ident, unmapped slot reads zero
   task t_ids;
      begin
         rd(`OP_MFC, `REG_PROCESSOR_IDENT, 64'h5a01);
         rd(`OP_MFC, `REG_STATUS, 64'h4);
         rd(`OP_MFC, `REG_CAUSE, 64'h7c);
         rd(`OP_MFC, 5'h1e, 64'h0);
      end
   endtask
   // word moves sign-extend, doubleword moves keep all 64 bits
   task t_moves;
      begin
         i_pipe.issue(`OP_MTC, 2'h0, `REG_EPC, 64'h1234_5678_8000_0000);
         rd(`OP_MFC, `REG_EPC, 64'hffff_ffff_8000_0000);
         i_pipe.issue(`OP_DMTC, 2'h0, `REG_EPC, 64'h1234_5678_9abc_def0);
         rd(`OP_DMFC, `REG_EPC, 64'h1234_5678_9abc_def0);
      end
   endtask
   // address error, then return through the saved pc
   task t_exc;
      begin
         i_pipe.issue(`OP_MTC, 2'h0, `REG_STATUS, 64'h30);
         @(negedge clk);
         chk("kernel", 0, kernel_mode);
         {exc_valid, exc_addr_err, exc_code, exc_badaddr, exc_pc} = {2'b11, 5'h04, 64'h0bad_0000, 64'h400};
         @(negedge clk);
         {exc_valid, exc_addr_err} = 2'b00;
         i_pipe.issue(`OP_MTC, 2'h0, `REG_FAULT, 64'h55);
         rd(`OP_DMFC, `REG_FAULT, 64'h0bad_0000);
         rd(`OP_MFC, `REG_CAUSE, 64'h10);
         chk("kernel", 1, kernel_mode);
         i_pipe.issue(`OP_ERET, 2'h0, 5'h0, 64'h0);
         chk("redirect", 2'b11, {redirect, squash_next});
         chk("ret_pc", 64'h400, redirect_pc);
         rd(`OP_MFC, `REG_STATUS, 64'h30);
         @(negedge clk);
         chk("kernel", 0, kernel_mode);
      end
   endtask
   // restore pops the mode pair at once, or waits for its jump; memory load path
   task t_restore;
      begin
         i_pipe.issue(`OP_RFE, 2'h0, 5'h0, 64'h0);
         rd(`OP_MFC, `REG_STATUS, 64'h3c);
         i_pipe.issue_in_slot(`OP_RFE);
         rd(`OP_MFC, `REG_STATUS, 64'h3c);
         i_pipe.commit_jump;
         rd(`OP_MFC, `REG_STATUS, 64'h3f);
         i_pipe.issue(`OP_LDC, 2'h0, `REG_CONFIG, 64'hffff_0000_0000_0abc);
         rd(`OP_DMFC, `REG_CONFIG, 64'h0abc);
         i_pipe.issue(`OP_MTC, 2'h0, `REG_STATUS, 64'h30);
         rd(`OP_MFC, `REG_STATUS, 64'h30);
         {exc_valid, exc_error} = 2'b11;
         @(negedge clk);
         {exc_valid, exc_error} = 2'b00;
         rd(`OP_MFC, `REG_STATUS, 64'h34);
         i_pipe.issue(`OP_ERET, 2'h0, 5'h0, 64'h0);
         rd(`OP_MFC, `REG_STATUS, 64'h30);
      end
   endtask
   // standby refuses requests until woken; other units are absent
   task t_wait;
      begin
         i_pipe.issue(`OP_WAIT, 2'h0, 5'h0, 64'h0);
         i_pipe.issue(`OP_MFC, 2'h0, `REG_PROCESSOR_IDENT, 64'h0);
         chk("standby", 2'b10, {standby, rd_valid});
         irq_wake = 1;
         @(negedge clk);
         irq_wake = 0;
         chk("wake", 0, standby);
         i_pipe.issue(`OP_MFC, 2'h2, `REG_PROCESSOR_IDENT, 64'h0);
         chk("unusable", 2'b10, {cop_unusable, rd_valid});
      end
   endtask
   initial begin
      {rst_n, exc_valid, exc_error, exc_addr_err, irq_wake, exc_code, exc_badaddr, exc_pc} = 0;
      repeat (8) @(negedge clk);
      rst_n = 1;
      t_ids;
      t_moves;
      t_exc;
      t_restore;
      t_wait;
      finish_test;
   end
   // the tests need well under 100 cycles
   initial begin #4000; error_cnt = error_cnt + 1; finish_test; end
endmodule
